//--- design/bus_timeout_timer.sv
// Watches one bus cycle and flags a missing slave answer.
// Assumes master and slave sync are synchronous levels on sys_clk.
`default_nettype none

module bus_timeout_timer #(
  parameter int LIMIT = trap_pkg::BUS_TIMEOUT_CYCLES
) (
  // Clock and reset.
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  // Bus handshake.
  input  wire logic masterSync,
  input  wire logic slaveSync,
  // One-cycle flag when the wait runs out.
  output logic      timeout
);

  // ==========================================================================
  // Wait counter.
  // ==========================================================================
  localparam int CW = $clog2(LIMIT + 1);
  localparam logic [CW-1:0] LIMIT_C = CW'(LIMIT);

  if (LIMIT < 2) begin : g_chk
    $error("bus_timeout_timer: LIMIT must be at least 2");
  end

  logic [CW-1:0] waitCnt_q;  // Cycles spent waiting for the slave.

  // The counter stops at the limit so one stuck cycle reports only once.
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !masterSync || slaveSync) begin
      waitCnt_q <= '0;
      timeout   <= 1'b0;
    end else begin
      if (waitCnt_q != LIMIT_C) begin
        waitCnt_q <= waitCnt_q + CW'(1);
      end
      timeout <= (waitCnt_q == LIMIT_C - CW'(1));
    end
  end

endmodule : bus_timeout_timer

`default_nettype wire

//--- design/processor_trap_sequencer.sv
// Trap sequencer: latches trap causes, saves status and counter on the
// stack, and loads a new counter and status from the cause's vector.
// Assumes a stack/vector port with one-cycle answers and synchronous inputs.
//
// Function
// - Power fail traps through vector 24.
// - Keep running 2 ms after power-fail trap.
// - Power restore traps again through vector 24.
// - Odd word address aborts, traps through 4.
// - Bus slave timeout aborts, traps through 4.
// - Reserved instruction traps through vector 10.
// - Other trap causes use own vectors.
// - Save status and counter, enter vector routine.
// - Push status first, counter second, predecrement.
// - Vector word one counter, word two status.
// - Return pops counter, then status.
`default_nettype none

module processor_trap_sequencer #(
  parameter int          POWER_SAVE = trap_pkg::POWER_SAVE_CYCLES,
  parameter int          TIMEOUT    = trap_pkg::BUS_TIMEOUT_CYCLES,
  parameter logic [15:0] VEC_STACK  = 16'h0004,  // Plain default.
  parameter logic [15:0] VEC_PARITY = 16'h0060,  // Plain default.
  parameter logic [15:0] VEC_MMU    = 16'h0064,  // Plain default.
  parameter logic [15:0] VEC_FP     = 16'h0068,  // Plain default.
  parameter logic [15:0] VEC_TRACE  = 16'h000C,  // Plain default.
  parameter logic [15:0] VEC_IO     = 16'h0010,  // Plain default.
  parameter logic [15:0] VEC_EMU    = 16'h0018,  // Plain default.
  parameter logic [15:0] VEC_TRAP   = 16'h001C   // Plain default.
) (
  // Clock and reset.
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  // Power monitor level, high while supply is good.
  input  wire logic        powerOk,
  // Cause pulses from the datapath.
  input  wire logic        wordAccess,
  input  wire logic        addrBit0,
  input  wire logic        stackError,
  input  wire logic        parityError,
  input  wire logic        mmuViolation,
  input  wire logic        fpException,
  input  wire logic        reservedInstr,
  input  wire logic        traceTrap,
  input  wire logic        io_trap_instruction,
  input  wire logic        emulator_trap_instruction,
  input  wire logic        trapInstr,
  input  wire logic        return_from_interrupt_instruction,
  // Processor bus handshake being watched.
  input  wire logic        masterSync,
  input  wire logic        slaveSync,
  // Current machine state.
  input  wire logic [15:0] processor_status_word,
  input  wire logic [15:0] program_counter_register,
  input  wire logic [15:0] stack_pointer_register,
  // Stack and vector memory port.
  output logic             memReq,
  output logic             memWrite,
  output logic [15:0]      memAddr,
  output logic [15:0]      memWdata,
  input  wire logic        memAck,
  input  wire logic [15:0] memRdata,
  // Results to the datapath.
  output logic             abortInstr,
  output logic             trapBusy,
  output logic             stateLoad,
  output logic [15:0]      newPc,
  output logic [15:0]      newStatus,
  output logic [15:0]      newSp,
  output logic             powerDownReady
);

  import trap_pkg::*;

  // ==========================================================================
  // Parameter checks.
  // ==========================================================================
  if (POWER_SAVE < 1 || TIMEOUT < 2) begin : g_chk
    $error("processor_trap_sequencer: POWER_SAVE >= 1 and TIMEOUT >= 2 required");
  end

  // ==========================================================================
  // Cause detection.
  // ==========================================================================
  logic                powerOk_q;  // Previous supply level for edge detection.
  logic                busTimeout; // Slave never answered.
  logic [NUM_SRC-1:0]  pend_q;     // Sticky pending causes.
  logic                retPend_q;  // Return request waiting for the sequencer.
  logic [NUM_SRC-1:0]  setVec;     // Causes raised this cycle.
  logic [NUM_SRC-1:0]  clrVec;     // Cause taken this cycle.
  logic [3:0]          pickIdx;    // Winning cause.
  logic                startTrap;  // Sequencer takes a trap now.
  logic                startRet;   // Sequencer takes a return now.
  seq_state_t          state_q;    // Sequencer state.

  bus_timeout_timer #(.LIMIT(TIMEOUT)) u_timer (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .masterSync(masterSync),
    .slaveSync (slaveSync),
    .timeout   (busTimeout)
  );

  // Raw cause vector; the supply edges come from the registered level.
  always_comb begin
    setVec              = '0;
    setVec[SRC_ODD]     = wordAccess && addrBit0;
    setVec[SRC_TIMEOUT] = busTimeout;
    setVec[SRC_PARITY]  = parityError;
    setVec[SRC_MMU]     = mmuViolation;
    setVec[SRC_STACK]   = stackError;
    setVec[SRC_PFAIL]   = powerOk_q && !powerOk;
    setVec[SRC_PREST]   = !powerOk_q && powerOk;
    setVec[SRC_FP]      = fpException;
    setVec[SRC_RSVD]    = reservedInstr;
    setVec[SRC_IO]      = io_trap_instruction;
    setVec[SRC_EMU]     = emulator_trap_instruction;
    setVec[SRC_TRAP]    = trapInstr;
    setVec[SRC_TRACE]   = traceTrap;
  end

  // Lowest index wins, so odd address and timeout go before anything else.
  always_comb begin
    pickIdx = 4'(NUM_SRC - 1);
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (pend_q[i]) begin
        pickIdx = 4'(i);
      end
    end
  end

  assign startTrap = (state_q == ST_IDLE) && (|pend_q);
  assign startRet  = (state_q == ST_IDLE) && !(|pend_q) && retPend_q;

  always_comb begin
    clrVec = '0;
    if (startTrap) begin
      clrVec[pickIdx] = 1'b1;
    end
  end

  // A cause that arrives as its bit is taken stays pending: set beats clear.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pend_q    <= '0;
      retPend_q <= 1'b0;
      powerOk_q <= 1'b1;
    end else begin
      pend_q    <= (pend_q & ~clrVec) | setVec;
      retPend_q <= (retPend_q && !startRet) || return_from_interrupt_instruction;
      powerOk_q <= powerOk;
    end
  end

  // Vector lookup; the shared bus-error vector serves odd address and timeout.
  function automatic logic [15:0] vecOf(input logic [3:0] idx);
    case (idx)
      4'(SRC_ODD), 4'(SRC_TIMEOUT): vecOf = VEC_BUS_ERROR;
      4'(SRC_PARITY):               vecOf = VEC_PARITY;
      4'(SRC_MMU):                  vecOf = VEC_MMU;
      4'(SRC_STACK):                vecOf = VEC_STACK;
      4'(SRC_PFAIL), 4'(SRC_PREST): vecOf = VEC_POWER;
      4'(SRC_FP):                   vecOf = VEC_FP;
      4'(SRC_RSVD):                 vecOf = VEC_RESERVED;
      4'(SRC_IO):                   vecOf = VEC_IO;
      4'(SRC_EMU):                  vecOf = VEC_EMU;
      4'(SRC_TRAP):                 vecOf = VEC_TRAP;
      default:                      vecOf = VEC_TRACE;
    endcase
  endfunction : vecOf

  // ==========================================================================
  // Sequencer and memory port.
  // ==========================================================================
  logic [15:0] vec_q;     // Vector of the trap in progress.
  logic [15:0] sp_q;      // Working stack pointer.
  logic [15:0] saveSt_q;  // Status captured at trap entry.
  logic [15:0] savePc_q;  // Counter captured at trap entry.
  logic        done;      // Memory answer for the current step.

  assign done = memReq && memAck;

  // Each memory step holds its request until the answer, then starts the next.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_q    <= ST_IDLE;
      memReq     <= 1'b0;
      memWrite   <= 1'b0;
      memAddr    <= '0;
      memWdata   <= '0;
      vec_q      <= '0;
      sp_q       <= '0;
      saveSt_q   <= '0;
      savePc_q   <= '0;
      abortInstr <= 1'b0;
      trapBusy   <= 1'b0;
      stateLoad  <= 1'b0;
      newPc      <= '0;
      newStatus  <= '0;
      newSp      <= '0;
    end else begin
      abortInstr <= 1'b0;
      stateLoad  <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (startTrap) begin
            // Only bus errors kill the running instruction.
            abortInstr <= (pickIdx == 4'(SRC_ODD)) ||
                          (pickIdx == 4'(SRC_TIMEOUT));
            vec_q      <= vecOf(pickIdx);
            saveSt_q   <= processor_status_word;
            savePc_q   <= program_counter_register;
            sp_q       <= stack_pointer_register - WORD_BYTES;
            memReq     <= 1'b1;
            memWrite   <= 1'b1;
            memAddr    <= stack_pointer_register - WORD_BYTES;
            memWdata   <= processor_status_word;
            trapBusy   <= 1'b1;
            state_q    <= ST_PUSH_ST;
          end else if (startRet) begin
            sp_q     <= stack_pointer_register;
            memReq   <= 1'b1;
            memWrite <= 1'b0;
            memAddr  <= stack_pointer_register;
            trapBusy <= 1'b1;
            state_q  <= ST_POP_PC;
          end
        end
        ST_PUSH_ST: begin
          if (done) begin
            sp_q     <= sp_q - WORD_BYTES;
            memAddr  <= sp_q - WORD_BYTES;
            memWdata <= savePc_q;
            state_q  <= ST_PUSH_PC;
          end
        end
        ST_PUSH_PC: begin
          if (done) begin
            memWrite <= 1'b0;
            memAddr  <= vec_q;
            state_q  <= ST_READ_PC;
          end
        end
        ST_READ_PC: begin
          if (done) begin
            newPc   <= memRdata;
            memAddr <= vec_q + WORD_BYTES;
            state_q <= ST_READ_ST;
          end
        end
        ST_POP_PC: begin
          if (done) begin
            newPc   <= memRdata;
            sp_q    <= sp_q + WORD_BYTES;
            memAddr <= sp_q + WORD_BYTES;
            state_q <= ST_POP_ST;
          end
        end
        ST_READ_ST, ST_POP_ST: begin
          if (done) begin
            newStatus <= memRdata;
            memReq    <= 1'b0;
            state_q   <= ST_LOAD;
            // Return steps past the status word; a trap leaves sp on the counter.
            if (state_q == ST_POP_ST) begin
              sp_q <= sp_q + WORD_BYTES;
            end
          end
        end
        ST_LOAD: begin
          stateLoad <= 1'b1;
          newSp     <= sp_q;
          trapBusy  <= 1'b0;
          state_q   <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
          memReq  <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================================
  // Power-fail save window.
  // ==========================================================================
  localparam int PW = $clog2(POWER_SAVE + 1);
  logic [PW-1:0] pwrCnt_q;  // Cycles left before the supply may be dropped.
  logic          pwrArm_q;  // Window running.
  logic          pfTaken;   // Power-fail trap entered now.

  assign pfTaken = startTrap && (pickIdx == 4'(SRC_PFAIL));

  // Nothing here halts the processor; it only tells the supply when the
  // software save time has been honoured. A restore cancels the window.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pwrCnt_q       <= '0;
      pwrArm_q       <= 1'b0;
      powerDownReady <= 1'b0;
    end else if (pfTaken) begin
      pwrCnt_q       <= PW'(POWER_SAVE);
      pwrArm_q       <= 1'b1;
      powerDownReady <= 1'b0;
    end else if (powerOk) begin
      pwrArm_q       <= 1'b0;
      powerDownReady <= 1'b0;
    end else if (pwrArm_q) begin
      if (pwrCnt_q == PW'(1)) begin
        pwrArm_q       <= 1'b0;
        powerDownReady <= 1'b1;
      end
      pwrCnt_q <= pwrCnt_q - PW'(1);
    end
  end

  // ==========================================================================
  // Assertions.
  // ==========================================================================
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  a_pf_vector: assert property (pfTaken |=> vec_q == VEC_POWER)
    else $error("power fail trap took wrong vector");
  a_pf_window: assert property (pfTaken ##1 !powerOk[*8] |-> !powerDownReady)
    else $error("power down allowed too early");
  a_restore_vec: assert property (startTrap && pickIdx == 4'(SRC_PREST) |=>
                                  vec_q == VEC_POWER)
    else $error("power restore trap took wrong vector");
  a_odd_abort: assert property (state_q == ST_IDLE && !(|pend_q) && wordAccess && addrBit0
                                |=> ##1 abortInstr && vec_q == VEC_BUS_ERROR)
    else $error("odd address did not abort through bus-error vector");
  a_timeout_abort: assert property (state_q == ST_IDLE && !(|pend_q) && busTimeout
                                    |=> ##1 abortInstr)
    else $error("timeout did not abort");
  a_rsvd_vector: assert property (startTrap && pickIdx == 4'(SRC_RSVD) |=>
                                  vec_q == VEC_RESERVED && !abortInstr)
    else $error("reserved instruction took wrong vector");
  a_push_order: assert property (state_q == ST_PUSH_ST && done |=>
                                 state_q == ST_PUSH_PC && memWdata == savePc_q &&
                                 memAddr == $past(memAddr) - WORD_BYTES)
    else $error("counter push out of order");
  a_vec_read: assert property (state_q == ST_READ_PC && done |=>
                               memAddr == vec_q + WORD_BYTES &&
                               newPc == $past(memRdata))
    else $error("vector words read out of order");
  a_prio_bus: assert property (startTrap && pend_q[SRC_ODD] |=>
                               abortInstr && vec_q == VEC_BUS_ERROR)
    else $error("bus error not served first");
  a_ret_pop: assert property (state_q == ST_POP_ST && done |=> ##1 stateLoad &&
                              newSp == $past(memAddr, 2) + WORD_BYTES)
    else $error("return did not pop two words");

  c_power_fail: cover property (pfTaken ##[1:40] stateLoad);
  c_odd_trap:   cover property (abortInstr ##[1:40] stateLoad);
  c_return:     cover property (startRet ##[1:40] stateLoad);
  c_set_clear:  cover property (startTrap && setVec[pickIdx]);

endmodule : processor_trap_sequencer

`default_nettype wire

//--- design/trap_pkg.sv
// Constants shared by the trap sequencer and its bus timeout timer.
// Assumes a 100 MHz system clock and 16-bit byte addresses.
`default_nettype none

package trap_pkg;

  // ==========================================================================
  // Clock and timing.
  // ==========================================================================
  localparam int CLK_PERIOD_NS = 10;  // System clock period in ns.
  localparam int BUS_TIMEOUT_NS = 10000;  // Wait for a slave answer, in ns.
  localparam int BUS_TIMEOUT_CYCLES = BUS_TIMEOUT_NS / CLK_PERIOD_NS;  // Longest time rounds down.
  localparam int POWER_SAVE_MS = 2;  // Guaranteed run time after power fail, in ms.
  localparam int POWER_SAVE_CYCLES = (POWER_SAVE_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================================
  // Fixed vectors (octal 4, 10 and 24 as byte addresses).
  // ==========================================================================
  localparam logic [15:0] VEC_BUS_ERROR = 16'h0004;  // Odd address and timeout.
  localparam logic [15:0] VEC_RESERVED  = 16'h0008;  // Illegal or reserved code.
  localparam logic [15:0] VEC_POWER     = 16'h0014;  // Power fail and restore.
  localparam logic [15:0] WORD_BYTES    = 16'h0002;  // Stack and vector step.

  // ==========================================================================
  // Trap sources, lowest index is served first.
  // ==========================================================================
  localparam int NUM_SRC     = 13;
  localparam int SRC_ODD     = 0;
  localparam int SRC_TIMEOUT = 1;
  localparam int SRC_PARITY  = 2;
  localparam int SRC_MMU     = 3;
  localparam int SRC_STACK   = 4;
  localparam int SRC_PFAIL   = 5;
  localparam int SRC_PREST   = 6;
  localparam int SRC_FP      = 7;
  localparam int SRC_RSVD    = 8;
  localparam int SRC_IO      = 9;
  localparam int SRC_EMU     = 10;
  localparam int SRC_TRAP    = 11;
  localparam int SRC_TRACE   = 12;

  // Sequencer states.
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_PUSH_ST = 3'b001,
    ST_PUSH_PC = 3'b010,
    ST_READ_PC = 3'b011,
    ST_READ_ST = 3'b100,
    ST_POP_PC  = 3'b101,
    ST_POP_ST  = 3'b110,
    ST_LOAD    = 3'b111
  } seq_state_t;

endpackage : trap_pkg

`default_nettype wire

//--- testbench/bus_slave_model.sv
// Behavioural model of the memory and peripheral slaves behind the trap sequencer.
// Assumes requests are held until acknowledged and everything moves on sys_clk.
`default_nettype none

module bus_slave_model (
  // Clock and reset.
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  // Answer control from the bench.
  input  wire logic [1:0]  ackDelay,
  input  wire logic        mute,
  // Stack and vector memory port.
  input  wire logic        memReq,
  input  wire logic        memWrite,
  input  wire logic [15:0] memAddr,
  input  wire logic [15:0] memWdata,
  output logic             memAck,
  output logic [15:0]      memRdata,
  // Watched bus handshake.
  input  wire logic        masterSync,
  output logic             slaveSync
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [15:0] ram [0:255];  // Word store, byte address bits 8:1; the bench preloads it.
  logic [1:0]  waitCnt;      // Cycles waited on the current request.
  logic [1:0]  syncDly;      // Slave answer pipeline.

  // ==========================================================================
  // Memory port.
  // ==========================================================================
  // Answers after ackDelay idle cycles. Outside an answer the read data flips
  // every cycle, so a sequencer that samples it late cannot read a stale match.
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      memAck   <= 1'h0;
      waitCnt  <= 2'h0;
      memRdata <= 16'h0000;
    end else if (memReq && !memAck && waitCnt == ackDelay) begin
      memAck  <= 1'h1;
      waitCnt <= 2'h0;
      if (memWrite) begin
        ram[memAddr[8:1]] <= memWdata;
      end else begin
        memRdata <= ram[memAddr[8:1]];
      end
    end else begin
      memAck   <= 1'h0;
      memRdata <= ~memRdata;
      if (memReq && !memAck) begin
        waitCnt <= waitCnt + 2'h1;
      end
    end
  end

  // ==========================================================================
  // Slave answer.
  // ==========================================================================
  // A present slave answers two cycles into a master cycle; a muted one never does.
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      syncDly <= 2'h0;
    end else begin
      syncDly <= {syncDly[0], masterSync & ~mute};
    end
  end
  assign slaveSync = syncDly[1] & masterSync;
endmodule : bus_slave_model

`default_nettype wire

//--- testbench/tb.sv
// Self-checking bench for the trap sequencer with a behavioural slave model.
// Assumes shortened counts: POWER_SAVE 20 cycles, TIMEOUT 8 cycles.
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        sys_clk, sys_rst, powerOk, wordAccess, addrBit0, ret, mute;
  logic        masterSync, slaveSync, memReq, memWrite, memAck;
  logic        abortInstr, trapBusy, stateLoad, powerDownReady;
  logic [12:0] cause;  // Pulse causes indexed by source number.
  logic [15:0] st, pc, sp, memAddr, memWdata, memRdata, newPc, newStatus, newSp;
  logic [1:0]  ackDelay;
  logic [32:0] acc [$];      // Completed accesses: write flag, address, data.
  logic [15:0] img [0:255];  // Bench copy of the preloaded vector words.
  int          num_errors = 0, cmp_count = 0, aborts = 0;

  processor_trap_sequencer #(.POWER_SAVE(20), .TIMEOUT(8)) uut (
    .sys_clk, .sys_rst, .powerOk, .wordAccess, .addrBit0,
    .stackError(cause[4]), .parityError(cause[2]), .mmuViolation(cause[3]),
    .fpException(cause[7]), .reservedInstr(cause[8]), .traceTrap(cause[12]),
    .io_trap_instruction(cause[9]), .emulator_trap_instruction(cause[10]),
    .trapInstr(cause[11]), .return_from_interrupt_instruction(ret),
    .masterSync, .slaveSync, .processor_status_word(st),
    .program_counter_register(pc), .stack_pointer_register(sp),
    .memReq, .memWrite, .memAddr, .memWdata, .memAck, .memRdata,
    .abortInstr, .trapBusy, .stateLoad, .newPc, .newStatus, .newSp, .powerDownReady);

  bus_slave_model slave (.sys_clk, .sys_rst, .ackDelay, .mute, .memReq, .memWrite,
    .memAddr, .memWdata, .memAck, .memRdata, .masterSync, .slaveSync);

  initial begin
    sys_clk = 1'h0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Log every completed access and every abort pulse, as seen before the edge.
  always @(posedge sys_clk) begin
    if (memReq === 1'h1 && memAck === 1'h1) acc.push_back({memWrite, memAddr, memWdata});
    if (abortInstr === 1'h1) aborts++;
  end

  // ==========================================================================
  // Checking helpers.
  // ==========================================================================
  // Vector byte address of each source, default parameters for the rest.
  function automatic logic [15:0] vecOf(input int s);
    case (s)
      0, 1, 4: return 16'h0004;
      2: return 16'h0060;
      3: return 16'h0064;
      5, 6: return 16'h0014;
      7: return 16'h0068;
      8: return 16'h0008;
      9: return 16'h0010;
      10: return 16'h0018;
      11: return 16'h001C;
      default: return 16'h000C;
    endcase
  endfunction : vecOf

  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : cmp16

  task automatic cmp1(input logic got, input logic exp, input string what);
    cmp16({15'h0000, got}, {15'h0000, exp}, what);
  endtask : cmp1

  // Pop one logged access and compare it; reads leave data to the load check.
  task automatic chkAcc(input logic w, input logic [15:0] a, input logic [15:0] d);
    logic [32:0] e;
    e = (acc.size() > 0) ? acc.pop_front() : 'x;
    cmp1(e[32], w, "access kind");
    cmp16(e[31:16], a, "access address");
    if (w) cmp16(e[15:0], d, "pushed word");
  endtask : chkAcc

  // Wait a bounded time for the load pulse, then check that busy drops with it.
  task automatic waitLoad();
    for (int n = 0; n < 200 && (n == 0 || stateLoad !== 1'h1); n++) begin
      @(posedge sys_clk);
      #1;
      if (trapBusy === 1'h1) begin
        masterSync = 1'h0;
        mute       = 1'h0;
      end
    end
    cmp1(stateLoad, 1'h1, "load pulse");
    cmp1(trapBusy, 1'h0, "busy at load");
  endtask : waitLoad

  // ==========================================================================
  // Stimulus.
  // ==========================================================================
  // New machine state, then raise cause s (plus any extra pulse causes).
  task automatic kick(input int s, input logic [12:0] extra);
    @(posedge sys_clk);
    #1;
    st     = 16'($urandom);
    pc     = 16'($urandom) & 16'hFFFE;
    sp     = 16'h0108 + 16'($urandom % 120) * 16'h0002;
    aborts = 0;
    cause  = extra;
    case (s)
      0: {wordAccess, addrBit0} = 2'h3;
      1: {masterSync, mute} = 2'h3;
      5: powerOk = 1'h0;
      6: powerOk = 1'h1;
      default: cause[s] = 1'h1;
    endcase
    @(posedge sys_clk);
    #1;
    {wordAccess, addrBit0} = 2'h0;
    cause = 13'h0000;
  endtask : kick

  // Whole trap: two pushes, two vector reads, then the load.
  task automatic expectTrap(input int s);
    logic [15:0] v;
    v = vecOf(s);
    waitLoad();
    chkAcc(1'h1, sp - 16'h0002, st);
    chkAcc(1'h1, sp - 16'h0004, pc);
    chkAcc(1'h0, v, 16'h0000);
    chkAcc(1'h0, v + 16'h0002, 16'h0000);
    cmp16(newPc, img[v[8:1]], "new counter");
    cmp16(newStatus, img[v[8:1] + 8'h01], "new status");
    cmp16(newSp, sp - 16'h0004, "new stack pointer");
    cmp16(16'(aborts), (s < 2) ? 16'h0001 : 16'h0000, "abort count");
  endtask : expectTrap

  // Return straight after a trap must pop exactly what that trap pushed.
  task automatic retCheck();
    logic [15:0] s0;
    s0 = sp;
    @(posedge sys_clk);
    #1;
    sp  = s0 - 16'h0004;
    ret = 1'h1;
    @(posedge sys_clk);
    #1;
    ret = 1'h0;
    waitLoad();
    chkAcc(1'h0, s0 - 16'h0004, 16'h0000);
    chkAcc(1'h0, s0 - 16'h0002, 16'h0000);
    cmp16(newPc, pc, "popped counter");
    cmp16(newStatus, st, "popped status");
    cmp16(newSp, s0, "popped stack pointer");
  endtask : retCheck

  task automatic results();
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results

  // A hang is cut after far more time than the tests need.
  initial begin
    #400000;
    num_errors++;
    $display("BAD %0t watchdog expired", $time);
    results();
  end

  initial begin
    int s, n;
    {cause, wordAccess, addrBit0, ret, mute, masterSync} = '0;
    {st, pc, ackDelay} = '0;
    sp      = 16'h0100;
    powerOk = 1'h1;
    sys_rst = 1'h1;
    void'($urandom(32'h4806));
    for (int i = 0; i < 256; i++) begin
      img[i]       = 16'($urandom);
      slave.ram[i] = img[i];
    end
    repeat (8) @(posedge sys_clk);
    #1;
    sys_rst = 1'h0;
    // Every source once except power fail and restore, which become reserved instruction, then random ones; slave latency random, some returns.
    for (int i = 0; i < 28; i++) begin
      s        = (i < 13) ? i : int'($urandom % 13);
      s        = (s == 5 || s == 6) ? 8 : s;
      ackDelay = 2'($urandom);
      kick(s, 13'h0000);
      expectTrap(s);
      if (i % 4 == 0) retCheck();
    end
    $display("test sources done");
    // Even word access and an answered bus cycle must not trap.
    @(posedge sys_clk);
    #1;
    {wordAccess, addrBit0, masterSync} = 3'h5;
    @(posedge sys_clk);
    #1;
    wordAccess = 1'h0;
    n          = 0;
    repeat (20) begin
      @(posedge sys_clk);
      #1;
      masterSync = masterSync & ~slaveSync;
      n += (trapBusy === 1'h0) ? 0 : 1;
    end
    cmp16(16'(n), 16'h0000, "spurious trap");
    $display("test no trap done");
    // Two causes in one cycle: parity before reserved instruction.
    kick(8, 13'h0004);
    expectTrap(2);
    expectTrap(8);
    $display("test priority done");
    // Power fail, save window, then restore.
    ackDelay = 2'h0;
    kick(5, 13'h0000);
    expectTrap(5);
    cmp1(powerDownReady, 1'h0, "ready early");
    repeat (10) @(posedge sys_clk);
    #1;
    cmp1(powerDownReady, 1'h0, "ready one cycle early");
    repeat (6) @(posedge sys_clk);
    #1;
    cmp1(powerDownReady, 1'h1, "ready after window");
    kick(6, 13'h0000);
    expectTrap(6);
    cmp1(powerDownReady, 1'h0, "ready after restore");
    $display("test power done");
    results();
  end
endmodule : tb

`default_nettype wire
